// ==== pkg/dso_regs.svh ====
// Register offsets, reset values, function codes and timing counts
// Assumes a 100 MHz clock and a 32-bit Wishbone register bus
`ifndef DSO_REGS_SVH
`define DSO_REGS_SVH

// ===========================================================
// Register byte offsets
`define DSO_FUNC_LO_OFS 8'h00
`define DSO_FUNC_HI_OFS 8'h04
`define DSO_POL_OFS 8'h08
`define DSO_ACW_OFS 8'h0c
`define DSO_THR1_OFS 8'h10
`define DSO_THR2_OFS 8'h14
`define DSO_FMAX_OFS 8'h18
`define DSO_WARN_OFS 8'h1c
`define DSO_RUNH_OFS 8'h20
`define DSO_PWRH_OFS 8'h24
`define DSO_STAT_OFS 8'h28

// ===========================================================
// Reset values
`define DSO_FUNC_LO_RST 32'h0000_0000
`define DSO_FUNC_HI_RST 16'h0500
`define DSO_POL_RST 6'h20
`define DSO_FMAX_RST 16'h1770

// ===========================================================
// Output function codes and alarm code widths
`define DSO_FN_RUN 8'h00
`define DSO_FN_CONST_SPEED 8'h01
`define DSO_FN_THR_EXCEEDED 8'h02
`define DSO_FN_ALARM 8'h05
`define DSO_FN_THR_REACHED 8'h06
`define DSO_FN_RUN_OVER 8'h0b
`define DSO_FN_POWER_OVER 8'h0c
`define DSO_FN_THR_EXCEEDED_2 8'h18
`define DSO_FN_THR_REACHED_2 8'h19
`define DSO_ACW_OFF 2'h0
`define DSO_ACW_3BIT 2'h1
`define DSO_ACW_4BIT 2'h2

// ===========================================================
// Hysteresis steps, warning units, timing
`define DSO_FON_PCT 2'h1
`define DSO_FOFF_PCT 2'h2
`define DSO_UNIT_10H 24'h00000a
`define DSO_UNIT_100H 24'h000064
`define DSO_HOURS_MAX 20'hfffff
`define DSO_CLK_PERIOD_NS 10
`define DSO_SECOND_NS 1000000000
`define DSO_SEC_PER_HOUR 3600

`endif

// ==== pkg/dso_pkg.sv ====
// Types shared by the drive status output logic
// Assumes dso_regs.svh for all register and timing constants
package dso_pkg;
  // ===========================================================
  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    DSO_WB_IDLE = 2'b01,
    DSO_WB_ACK = 2'b10
  } dso_wb_st_t;

  // Drive status seen by the block
  typedef struct packed {
    logic running;
    logic dc_brake;
    logic accel;
    logic decel;
    logic fault;
    logic [3:0] fault_code;
    logic [15:0] freq;
    logic [15:0] cmd_freq;
  } dso_drive_t;

  // Internal indications selectable per output
  typedef struct packed {
    logic run;
    logic [4:0] fa;
    logic alarm;
    logic run_over;
    logic power_over;
  } dso_sig_t;

  typedef struct packed {
    logic flag;
  } dso_fa_state_t;

  typedef struct packed {
    logic [11:0] sec;
    logic [19:0] hours;
  } dso_hc_state_t;

  typedef struct packed {
    dso_wb_st_t wb;
    logic [31:0] rdat;
    logic [31:0] func_lo;
    logic [15:0] func_hi;
    logic [5:0] pol;
    logic [1:0] acw;
    logic [31:0] thr1;
    logic [31:0] thr2;
    logic [15:0] fmax;
    logic [16:0] warn;
    logic [26:0] div;
    logic [4:0] outs;
    logic pair1;
  } dso_state_t;
endpackage

// ==== rtl/dso_freq_arrival.sv ====
// One frequency-arrival detector with hysteresis
// Assumes frequencies in 0.01 Hz steps on the system clock
`timescale 1ns/1ps
`default_nettype none
module dso_freq_arrival
  import dso_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] freq_i,
  input wire logic [15:0] accel_thr_i,
  input wire logic [15:0] decel_thr_i,
  input wire logic [15:0] fon_i,
  input wire logic [15:0] foff_i,
  input wire logic accel_i,
  input wire logic decel_i,
  input wire logic window_i,
  output logic flag_o
);
  dso_fa_state_t q, d;
  logic signed [17:0] thr, f, on_step, off_step;

  // Threshold in use follows the ramp direction
  assign thr = $signed({2'b00, decel_i ? decel_thr_i : accel_thr_i});
  assign f = $signed({2'b00, freq_i});
  assign on_step = $signed({2'b00, fon_i});
  assign off_step = $signed({2'b00, foff_i});

  // Hysteresis decision
  always_comb begin
    d = q;
    if (thr == 18'sh0) begin
      d.flag = 1'b0; // [R12]
    end else if (!window_i) begin
      if (!q.flag && f >= thr - on_step) d.flag = 1'b1; // [R9] [R14]
      else if (q.flag && f < thr - off_step) d.flag = 1'b0; // [R9]
    end else if (accel_i) begin
      if (!q.flag && f >= thr - on_step && f <= thr + off_step)
        d.flag = 1'b1; // [R10] [R15]
      else if (q.flag && f > thr + off_step) d.flag = 1'b0; // [R10]
    end else if (decel_i) begin
      if (!q.flag && f <= thr + on_step && f >= thr - off_step)
        d.flag = 1'b1; // [R11] [R15]
      else if (q.flag && f < thr - off_step) d.flag = 1'b0; // [R11]
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) q <= '{flag: 1'b0};
    else q <= d;
  end

  assign flag_o = q.flag;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  thr_disable_a: assert property (thr == 18'sh0 |=> !flag_o) // [R12]
    else $error("arrival flag set with zero threshold");
  hyst_on_a: assert property ( // [R9]
    (!window_i && thr != 18'sh0 && f >= thr - on_step) |=> flag_o)
    else $error("arrival flag missed its on level");
  win_accel_a: assert property ( // [R10]
    (window_i && accel_i && !decel_i && f > thr + off_step) |=> !flag_o)
    else $error("reached flag held above window");
  win_decel_a: assert property ( // [R11]
    (window_i && decel_i && !accel_i && f < thr - off_step) |=> !flag_o)
    else $error("reached flag held below window");
endmodule
`default_nettype wire

// ==== rtl/dso_hour_counter.sv ====
// Cumulative hour counter advanced by a one-second enable pulse
// Assumes tick_i is a single-cycle pulse from the system divider
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.svh"
module dso_hour_counter
  import dso_pkg::*;
#(
  parameter int SEC_PER_HOUR = `DSO_SEC_PER_HOUR
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic en_i,
  output logic [19:0] hours_o
);
  localparam logic [11:0] SecLast = 12'(SEC_PER_HOUR - 1);
  dso_hc_state_t q, d;

  // Seconds roll into saturating hours
  always_comb begin
    d = q;
    if (tick_i && en_i) begin
      if (q.sec == SecLast) begin
        d.sec = 12'h000;
        if (q.hours != `DSO_HOURS_MAX) d.hours = q.hours + 20'h00001; // [R19]
      end else begin
        d.sec = q.sec + 12'h001;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) q <= '{sec: 12'h000, hours: 20'h00000};
    else q <= d;
  end

  assign hours_o = q.hours;

  hour_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    (tick_i && en_i && q.sec == SecLast && q.hours != `DSO_HOURS_MAX)
    |=> hours_o == $past(hours_o) + 20'h00001)
    else $error("hour counter did not advance");
endmodule
`default_nettype wire

// ==== rtl/dso_top.sv ====
// Drive status output logic: indications, polarity and relay
// Assumes drive status on the same clock and a classic Wishbone master
//
// How it works
// R1 - Each output and relay has own polarity
// R2 - Normally open: active signal closes output
// R3 - Normally closed: active signal opens output
// R4 - Relay polarity 0: pair one closes on error
// R5 - Relay polarity 1 default: pair one closed normally
// R6 - Function 00 shows drive running
// R7 - Running stays on during DC braking
// R8 - Five arrival functions selectable per output
// R9 - Arrival on at target-1%, off target-2%
// R10 - Reached, accelerating: off above target+2%
// R11 - Reached, decelerating: on at target+1%
// R12 - Zero arrival threshold disables that output
// R13 - Constant speed tracks commanded frequency
// R14 - Exceeded flags use threshold pair one/two
// R15 - Reached flags only near threshold pair
// R16 - Time-over flags when hours exceed warning
// R17 - Warning zero off, 10 or 100 hour units
// R18 - Controller brakes on arrival, releases on torque; the model has no torque input and releases when the arrival terminal opens
// R19 - Separate run and power hour counters readable
// R20 - Alarm code width overrides first terminals
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.svh"
module dso_top
  import dso_pkg::*;
#(
  parameter int TICKS_PER_SEC = `DSO_SECOND_NS / `DSO_CLK_PERIOD_NS,
  parameter int SEC_PER_HOUR = `DSO_SEC_PER_HOUR
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dso_drive_t drive_i,
  output logic [4:0] out_closed_o,
  output logic relay_pair1_closed_o,
  output logic relay_pair2_closed_o
);
  localparam logic [26:0] TickLast = 27'(TICKS_PER_SEC - 1);

  dso_state_t q, d;
  dso_sig_t sig;
  logic [15:0] fon, foff;
  logic [4:0] fa;
  logic [19:0] run_hours, power_hours;
  logic [23:0] warn_hours;
  logic sec_tick;
  logic [31:0] rd_word;
  logic [15:0] thr_a [5];
  logic [15:0] thr_d [5];
  logic [4:0] win;

  // ===========================================================
  // Helper functions

  // Percent of maximum frequency, truncated
  function automatic logic [15:0] pct_of(input logic [15:0] f,
                                         input logic [1:0] n);
    logic [17:0] p;
    p = {2'b00, f} * {16'h0000, n};
    pct_of = 16'(p / 18'd100);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    merge = r;
  endfunction

  // Indication chosen by a function code
  function automatic logic pick(input logic [7:0] code,
                                input dso_sig_t s);
    logic r;
    r = 1'b0;
    case (code)
      `DSO_FN_RUN: r = s.run; // [R6]
      `DSO_FN_CONST_SPEED: r = s.fa[0]; // [R8]
      `DSO_FN_THR_EXCEEDED: r = s.fa[1]; // [R8]
      `DSO_FN_THR_REACHED: r = s.fa[2]; // [R8]
      `DSO_FN_THR_EXCEEDED_2: r = s.fa[3]; // [R8]
      `DSO_FN_THR_REACHED_2: r = s.fa[4]; // [R8]
      `DSO_FN_ALARM: r = s.alarm;
      `DSO_FN_RUN_OVER: r = s.run_over;
      `DSO_FN_POWER_OVER: r = s.power_over;
      default: r = 1'b0;
    endcase
    pick = r;
  endfunction

  // Function code held for one terminal
  function automatic logic [7:0] code_of(input logic [31:0] lo,
                                         input logic [15:0] hi,
                                         input int idx);
    code_of = (idx < 4) ? lo[8*(idx % 4) +: 8] : hi[7:0];
  endfunction

  // ===========================================================
  // Frequency-arrival detectors

  // Hysteresis steps from maximum frequency
  assign fon = pct_of(q.fmax, `DSO_FON_PCT); // [R9]
  assign foff = pct_of(q.fmax, `DSO_FOFF_PCT); // [R9]

  // Constant speed uses the commanded frequency both ways
  assign thr_a[0] = drive_i.cmd_freq; // [R13]
  assign thr_d[0] = drive_i.cmd_freq; // [R13]
  assign thr_a[1] = q.thr1[15:0]; // [R14]
  assign thr_d[1] = q.thr1[31:16]; // [R14]
  assign thr_a[2] = q.thr1[15:0]; // [R15]
  assign thr_d[2] = q.thr1[31:16]; // [R15]
  assign thr_a[3] = q.thr2[15:0]; // [R14]
  assign thr_d[3] = q.thr2[31:16]; // [R14]
  assign thr_a[4] = q.thr2[15:0]; // [R15]
  assign thr_d[4] = q.thr2[31:16]; // [R15]
  assign win = 5'b10100;

  // One detector per arrival function
  for (genvar g = 0; g < 5; g++) begin : g_fa
    dso_freq_arrival u_fa (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .freq_i(drive_i.freq),
      .accel_thr_i(thr_a[g]),
      .decel_thr_i(thr_d[g]),
      .fon_i(fon),
      .foff_i(foff),
      .accel_i(drive_i.accel),
      .decel_i(drive_i.decel),
      .window_i(win[g]),
      .flag_o(fa[g])
    );
  end

  // ===========================================================
  // Elapsed time

  // One-second enable pulse
  assign sec_tick = (q.div == TickLast);

  dso_hour_counter #(
    .SEC_PER_HOUR(SEC_PER_HOUR)
  ) u_run_hours (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(sec_tick),
    .en_i(drive_i.running),
    .hours_o(run_hours)
  );

  dso_hour_counter #(
    .SEC_PER_HOUR(SEC_PER_HOUR)
  ) u_power_hours (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(sec_tick),
    .en_i(1'b1),
    .hours_o(power_hours)
  );

  // Warning time scaled to hours
  assign warn_hours = {8'h00, q.warn[15:0]} *
    (q.warn[16] ? `DSO_UNIT_100H : `DSO_UNIT_10H); // [R17]

  // ===========================================================
  // Indications

  always_comb begin
    sig.run = drive_i.running | drive_i.dc_brake; // [R6] [R7]
    sig.fa = fa;
    sig.alarm = drive_i.fault;
    sig.run_over = (q.warn[15:0] != 16'h0000) &&
                   ({4'h0, run_hours} > warn_hours); // [R16] [R17]
    sig.power_over = (q.warn[15:0] != 16'h0000) &&
                     ({4'h0, power_hours} > warn_hours); // [R16] [R17]
  end

  // ===========================================================
  // Register read mux

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      `DSO_FUNC_LO_OFS: rd_word = q.func_lo;
      `DSO_FUNC_HI_OFS: rd_word = {16'h0000, q.func_hi};
      `DSO_POL_OFS: rd_word = {26'h0, q.pol};
      `DSO_ACW_OFS: rd_word = {30'h0, q.acw};
      `DSO_THR1_OFS: rd_word = q.thr1;
      `DSO_THR2_OFS: rd_word = q.thr2;
      `DSO_FMAX_OFS: rd_word = {16'h0000, q.fmax};
      `DSO_WARN_OFS: rd_word = {15'h0, q.warn};
      `DSO_RUNH_OFS: rd_word = {12'h000, run_hours}; // [R19]
      `DSO_PWRH_OFS: rd_word = {12'h000, power_hours}; // [R19]
      `DSO_STAT_OFS: rd_word = {17'h0, q.pair1, q.outs, sig};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ===========================================================
  // Next state: bus slave, divider, outputs

  always_comb begin
    logic s;
    s = 1'b0;
    d = q;
    // Bus slave: take, then acknowledge and write
    case (q.wb)
      DSO_WB_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          d.wb = DSO_WB_ACK;
          d.rdat = rd_word;
        end
      end
      DSO_WB_ACK: begin
        d.wb = DSO_WB_IDLE;
        if (wb_we_i) begin
          case (wb_adr_i)
            `DSO_FUNC_LO_OFS: d.func_lo = merge(q.func_lo, wb_dat_i,
                                                wb_sel_i);
            `DSO_FUNC_HI_OFS: d.func_hi = 16'(merge({16'h0000, q.func_hi},
                                          wb_dat_i, wb_sel_i));
            `DSO_POL_OFS: d.pol = 6'(merge({26'h0, q.pol}, wb_dat_i,
                                     wb_sel_i)); // [R1]
            `DSO_ACW_OFS: d.acw = 2'(merge({30'h0, q.acw}, wb_dat_i,
                                     wb_sel_i));
            `DSO_THR1_OFS: d.thr1 = merge(q.thr1, wb_dat_i, wb_sel_i);
            `DSO_THR2_OFS: d.thr2 = merge(q.thr2, wb_dat_i, wb_sel_i);
            `DSO_FMAX_OFS: d.fmax = 16'(merge({16'h0000, q.fmax},
                                       wb_dat_i, wb_sel_i));
            `DSO_WARN_OFS: d.warn = 17'(merge({15'h0, q.warn},
                                       wb_dat_i, wb_sel_i)); // [R17]
            default: d.wb = DSO_WB_IDLE;
          endcase
        end
      end
      default: d.wb = DSO_WB_IDLE;
    endcase

    // Second divider
    d.div = sec_tick ? 27'h0 : q.div + 27'h1;

    // Open-collector outputs with polarity
    for (int i = 0; i < 5; i++) begin
      s = pick(code_of(q.func_lo, q.func_hi, i), sig);
      if ((q.acw == `DSO_ACW_3BIT && i < 3) ||
          (q.acw == `DSO_ACW_4BIT && i < 4)) begin
        s = drive_i.fault_code[2'(i)]; // [R20]
      end
      d.outs[i] = s ^ q.pol[i]; // [R1] [R2] [R3]
    end

    // Relay coil: pair one follows energised coil
    d.pair1 = pick(q.func_hi[15:8], sig) ^ q.pol[5]; // [R4] [R5]
  end

  // ===========================================================
  // State register; reset leaves contacts as unpowered

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{wb: DSO_WB_IDLE, rdat: 32'h0, func_lo: `DSO_FUNC_LO_RST,
             func_hi: `DSO_FUNC_HI_RST, pol: `DSO_POL_RST,
             acw: `DSO_ACW_OFF, thr1: 32'h0, thr2: 32'h0,
             fmax: `DSO_FMAX_RST, warn: 17'h0, div: 27'h0,
             outs: 5'h00, pair1: 1'b0}; // [R5]
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign wb_ack_o = (q.wb == DSO_WB_ACK);
  assign wb_dat_o = q.rdat;
  assign out_closed_o = q.outs;
  assign relay_pair1_closed_o = q.pair1;
  assign relay_pair2_closed_o = ~q.pair1; // [R4] [R5]

  // ===========================================================
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence req_s;
    wb_cyc_i && wb_stb_i && q.wb == DSO_WB_IDLE;
  endsequence

  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  wb_ack_timing_a: assert property (req_s |=> ack_pulse_s)
    else $error("bus ack not a single cycle after request");
  run_indication_a: assert property ( // [R6] [R7]
    (q.func_lo[7:0] == `DSO_FN_RUN && q.acw == `DSO_ACW_OFF &&
     drive_i.dc_brake && !wb_ack_o) |=> out_closed_o[0] != $past(q.pol[0]))
    else $error("running indication lost during braking");
  no_contact_a: assert property ( // [R2]
    (q.func_hi[7:0] == `DSO_FN_ALARM && !q.pol[4] && !wb_ack_o)
    |=> out_closed_o[4] == $past(drive_i.fault))
    else $error("normally open output wrong");
  nc_contact_a: assert property ( // [R3]
    (q.func_hi[7:0] == `DSO_FN_ALARM && q.pol[4] && !wb_ack_o)
    |=> out_closed_o[4] == !$past(drive_i.fault))
    else $error("normally closed output wrong");
  relay_error_a: assert property ( // [R4] [R5]
    (q.func_hi[15:8] == `DSO_FN_ALARM && !wb_ack_o)
    |=> relay_pair1_closed_o == ($past(drive_i.fault) ^ $past(q.pol[5])))
    else $error("relay pair one wrong for fault");
  relay_unpowered_a: assert property (@(posedge clk_i) // [R5]
    disable iff (1'b0)
    rst_i |=> !relay_pair1_closed_o && relay_pair2_closed_o)
    else $error("relay not in unpowered state after reset");
  code_override_a: assert property ( // [R20]
    (q.acw == `DSO_ACW_4BIT && !q.pol[3] && !wb_ack_o)
    |=> out_closed_o[3] == $past(drive_i.fault_code[3]))
    else $error("alarm code not on terminal four");
  warn_off_a: assert property ( // [R17]
    (q.warn[15:0] == 16'h0000 && q.func_hi[7:0] == `DSO_FN_POWER_OVER &&
     !q.pol[4] && !wb_ack_o) |=> !out_closed_o[4])
    else $error("time-over flag with warning disabled");
  run_time_a: assert property ( // [R16]
    (q.warn[15:0] != 16'h0000 && {4'h0, run_hours} > warn_hours)
    ##1 (q.warn == $past(q.warn)) |-> sig.run_over)
    else $error("run time over not flagged");
endmodule
`default_nettype wire

// ==== sim/dso_ctrl_model.sv ====
// External controller model that reads the status outputs
// Assumes outputs are sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module dso_ctrl_model (
  input wire logic clk_i,
  input wire logic [4:0] out_closed_i,
  input wire logic pair1_i,
  input wire logic pair2_i,
  input wire logic [2:0] arrive_sel_i,
  output logic brake_o,
  output logic fault_seen_o
);
  // ===========================================================
  // Brake start follows the chosen arrival terminal
  always_ff @(posedge clk_i) begin
    brake_o <= out_closed_i[arrive_sel_i];
    fault_seen_o <= pair1_i & ~pair2_i;
  end
endmodule
`default_nettype wire

// ==== sim/tb_drive_status_output_logic.sv ====
// Self-checking bench for the drive status output logic
// Assumes fast tick and hour parameters on the top module
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_drive_status_output_logic
  import dso_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, a, b;
  logic ack, p1, p2, brake, fseen;
  logic [4:0] outs;
  dso_drive_t drv = '0;
  int n_mismatch = 0, cmp_count = 0;
  logic [15:0] fq [8] = '{16'h0b7b, 16'h0b7c, 16'h0c30, 16'h0c31,
                          16'h0bf5, 16'h0bf4, 16'h0b41, 16'h0b3f};
  logic [3:0] ex [8] = '{4'h0, 4'hf, 4'hf, 4'hd, 4'hd, 4'hf, 4'hf, 4'h0};
  // ===========================================================
  // Clock and design
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  dso_top #(.TICKS_PER_SEC(4), .SEC_PER_HOUR(2)) DUT (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .drive_i(drv), .out_closed_o(outs),
    .relay_pair1_closed_o(p1), .relay_pair2_closed_o(p2));
  dso_ctrl_model ctrl (.clk_i(clk_i), .out_closed_i(outs), .pair1_i(p1),
    .pair2_i(p2), .arrive_sel_i(3'h1), .brake_o(brake),
    .fault_seen_o(fseen));
  // ===========================================================
  // Bus and timing helpers
  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ===========================================================
  // Scenarios
  task automatic t_reset();
    wb(0, 8'h04, 0); `CHK("func_hi", 32'h0000_0500, q)
    wb(0, 8'h08, 0); `CHK("pol", 32'h0000_0020, q)
    wb(0, 8'h18, 0); `CHK("fmax", 32'h0000_1770, q)
    wb(0, 8'h3c, 0); `CHK("unmapped", 32'h0, q)
  endtask
  task automatic t_relay();
    wb(1, 8'h04, 32'h0000_0505);
    step(3); `CHK("nc normal", 3'b100, {p1, p2, outs[4]})
    drv.fault <= 1'b1;
    step(3); `CHK("nc error", 3'b011, {p1, p2, outs[4]})
    wb(1, 8'h08, 32'h10);
    step(3); `CHK("no error", 3'b100, {p1, p2, outs[4]})
    `CHK("model fault", 1'b1, fseen)
    drv.fault <= 1'b0;
    step(3); `CHK("no normal", 3'b011, {p1, p2, outs[4]})
    wb(1, 8'h08, 0);
    wb(1, 8'h04, 32'h0000_0500);
  endtask
  task automatic t_run();
    drv.running <= 1'b1;
    step(3); `CHK("run no", 5'h1f, outs)
    wb(1, 8'h08, 32'h21);
    step(3); `CHK("run nc", 5'h1e, outs)
    drv.running <= 1'b0;
    drv.dc_brake <= 1'b1;
    step(3); `CHK("dc brake", 5'h1e, outs)
    drv.dc_brake <= 1'b0;
    step(3); `CHK("stopped", 5'h01, outs)
    wb(1, 8'h08, 0);
  endtask
  task automatic t_arrival();
    wb(1, 8'h00, 32'h0106_0200);
    wb(1, 8'h04, 32'h0000_0518);
    wb(1, 8'h10, 32'h0bb8_0bb8);
    wb(1, 8'h14, 32'h0bb8_0bb8);
    drv.cmd_freq <= 16'h0bb8;
    drv.running <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      drv.accel <= (i < 4);
      drv.decel <= (i >= 4);
      drv.freq <= fq[i];
      step(4);
      `CHK("fa", ex[i], outs[4:1])
    end
    `CHK("brake model", 1'b0, brake)
    wb(1, 8'h10, 0);
    wb(1, 8'h04, 32'h0000_0519);
    drv.accel <= 1'b1;
    drv.decel <= 1'b0;
    drv.freq <= 16'h0bb8;
    step(4); `CHK("zero thr", 4'hc, outs[4:1])
    drv.running <= 1'b0;
    wb(1, 8'h00, 0);
    wb(1, 8'h04, 32'h0000_0500);
  endtask
  task automatic t_acode();
    drv.fault_code <= 4'hd;
    wb(1, 8'h0c, 32'h1);
    step(3); `CHK("code 3 bit", 5'h05, outs)
    wb(1, 8'h0c, 32'h2);
    step(3); `CHK("code 4 bit", 5'h0d, outs)
    wb(1, 8'h0c, 0);
  endtask
  task automatic t_hours();
    wb(0, 8'h20, 0);
    a = q;
    step(40);
    wb(0, 8'h20, 0); `CHK("run idle", a, q)
    wb(1, 8'h20, 32'h55); wb(0, 8'h20, 0); `CHK("run ro", a, q)
    drv.running <= 1'b1;
    step(160);
    drv.running <= 1'b0;
    wb(0, 8'h20, 0);
    b = q - a;
    `CHK("run count", 1'b1, (b >= 32'd18 && b <= 32'd22))
    wb(0, 8'h28, 0); `CHK("warn off", 2'b00, q[1:0])
    wb(1, 8'h1c, 32'h0000_0001);
    wb(1, 8'h04, 32'h0000_000c);
    wb(0, 8'h28, 0); `CHK("warn 10h", 2'b11, q[1:0])
    step(3); `CHK("power over out", 1'b1, outs[4])
    wb(1, 8'h1c, 32'h0001_003c);
    wb(0, 8'h28, 0); `CHK("warn 100h", 2'b00, q[1:0])
    wb(1, 8'h1c, 32'h0);
    step(3); `CHK("warn zero", 1'b0, outs[4])
  endtask
  // ===========================================================
  // Main sequence and watchdog
  initial begin
    step(3);
    rst_i <= 1'b0;
    t_reset();
    t_relay();
    t_run();
    t_arrival();
    t_acode();
    t_hours();
    end_sim();
  end
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
